// >>> hdl/arb_pkg.sv
// Purpose: Shared constants and types for the submission queue arbiter
// Assumes: 8 queues of 16 slots, queue 0 is the administrative queue
// Notes:   Offsets are byte addresses on the plain register port
package arb_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_Q = 8;
  localparam int QW    = 3;
  localparam int PW    = 4;
  localparam int CW    = 9;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WEIGHT = 8'h04;
  localparam logic [7:0] OFS_QCLASS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CAP    = 8'h10;
  localparam logic [2:0] DB_PAGE    = 3'h1;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_WRR_BIT  = 0;
  localparam int CTRL_BURST_LSB = 1;
  localparam int WT_HIGH_LSB   = 0;
  localparam int WT_MED_LSB    = 8;
  localparam int WT_LOW_LSB    = 16;
  localparam int ST_Q_LSB      = 0;
  localparam int ST_STATE_LSB  = 3;
  localparam int ST_CR_LSB     = 5;
  localparam logic [3:0]    CTRL_RST   = 4'h0;
  localparam logic [23:0]   WEIGHT_RST = 24'h000000;
  localparam logic [15:0]   QCLASS_RST = 16'hFFFF;
  localparam logic [CW-1:0] CREDIT_RST = 9'h001;
  localparam logic [2:0]    BURST_NOLIMIT = 3'h7;
  // Weighted with urgent class offered, vendor specific not offered
  localparam logic [1:0]    CAP_VALUE  = 2'h1;
  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {
    CLS_URGENT = 2'b00, CLS_HIGH = 2'b01, CLS_MED = 2'b10, CLS_LOW = 2'b11
  } qclass_e;
  typedef enum logic [1:0] {
    FU_NONE = 2'b00, FU_FIRST = 2'b01, FU_SECOND = 2'b10
  } fuse_e;
  typedef enum logic [1:0] {
    SC_OK = 2'b00, SC_ABORT_FUSED = 2'b01, SC_INVALID_FIELD = 2'b10
  } status_e;
  typedef enum logic [1:0] {
    AS_ARB = 2'b00, AS_RUN = 2'b01, AS_FUSE = 2'b10
  } arb_state_e;
endpackage

// >>> hdl/sq_arbiter.sv
// Purpose: Picks the submission queue from which commands start processing
// Assumes: Host keeps one slot free per queue; start outputs feed the executor
// Notes:   One command start per cycle at most
//
// Behaviour
// - Plain round robin over all queues, admin included, at equal priority.
// - After a pick, start at most the burst count, then arbitrate again; a fused second half may start one past it.
// - A command is submitted once the tail doorbell moves past its slot.
// - Candidates may be picked in any order; completions order is unconstrained.
// - Effects of a completed command are visible to later commands.
// - Weighted scheme has three strict classes; lowest has high, medium, low.
// - Higher strict class candidates start before any lower class candidate.
// - Admin queue is the top class under the weighted scheme.
// - Urgent queues follow admin, before weighted levels, picked by plain round robin among them.
// - Host programs level weights; remaining bandwidth shared by those weights.
// - Queues of one weighted level are picked by plain round robin.
// - Weighted starts per round are the lesser of burst and level credits.
// - Fused pair starts together, first then second; may count as two.
// - Fused pair is atomic; nothing starts between its two halves.
// - First half failing aborts the second half.
// - Fused halves with mismatched block ranges are both aborted, invalid field.
// - Each fused half is aborted separately and completes separately.
// - A capability field advertises the optional arbitration mechanisms.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
module sq_arbiter import arb_pkg::*; (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Register port
  input  wire logic [7:0]       addr_in,
  input  wire logic [31:0]      wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [31:0]      rdata_out,
  // Head entry information per queue, first-half failure and start hold
  input  wire logic [NUM_Q-1:0] fused_first_in,
  input  wire logic [NUM_Q-1:0] lba_mismatch_in,
  input  wire logic             first_fail_in,
  input  wire logic             hold_in,
  // Command start and capability field
  output logic                  start_valid_out,
  output logic      [QW-1:0]    start_qid_out,
  output logic      [PW-1:0]    start_slot_out,
  output logic      [1:0]       start_fused_out,
  output logic      [1:0]       start_status_out,
  output logic      [1:0]       capability_arbitration_support_out
);
  // ****************************************
  // State
  // ****************************************
  arb_state_e    state_reg, state_next;
  logic [3:0]    ctrl_reg, ctrl_next;
  logic [23:0]   weight_reg, weight_next;
  logic [15:0]   qclass_reg, qclass_next;
  logic [PW-1:0] tail_reg [NUM_Q], tail_next [NUM_Q];
  logic [PW-1:0] head_reg [NUM_Q], head_next [NUM_Q];
  logic [QW-1:0] last_reg [5], last_next [5];
  logic [CW-1:0] credit_reg [3], credit_next [3];
  logic [QW-1:0] cur_q_reg, cur_q_next;
  logic [CW-1:0] left_reg, left_next;
  logic          wrr_reg, wrr_next;
  logic [1:0]    lvl_reg, lvl_next;
  logic [1:0]    fst_reg, fst_next;
  logic [31:0]   rdata_reg, rdata_next;
  logic          sv_reg, sv_next;
  logic [QW-1:0] sq_reg, sq_next;
  logic [PW-1:0] ss_reg, ss_next;
  logic [1:0]    sf_reg, sf_next;
  logic [1:0]    sc_reg, sc_next;
  logic [1:0]    cap_reg;

  logic [NUM_Q-1:0] pend;
  logic [NUM_Q-1:0] cls_mask [4];
  logic [CW-1:0]    burst_lim, lim_c;
  logic             reload_c, issue_c;

  // ****************************************
  // Per-queue pending and class masks
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_Q; g++) begin : g_q
      assign pend[g] = tail_reg[g] != head_reg[g];
      for (genvar c = 0; c < 4; c++) begin : g_c
        assign cls_mask[c][g] = pend[g] && (g != 0) && (qclass_reg[2*g+:2] == 2'(c));
      end
    end
  endgenerate

  // Rotating pick after the last winner; any order of candidates is legal
  function automatic logic [QW:0] rr_pick(input logic [NUM_Q-1:0] m,
                                          input logic [QW-1:0] last);
    logic [QW:0]   r;
    logic [QW-1:0] k;
    r = '0;
    for (int i = NUM_Q; i >= 1; i--) begin
      k = last + QW'(i);
      if (m[k]) r = {1'b1, k};
    end
    return r;
  endfunction

  assign burst_lim = (ctrl_reg[3:1] == BURST_NOLIMIT) ? '1 : (CW'(1) << ctrl_reg[3:1]);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [QW:0] p;
    logic [1:0]  fl;
    p = '0;
    fl = '0;
    state_next  = state_reg;
    ctrl_next   = ctrl_reg;
    weight_next = weight_reg;
    qclass_next = qclass_reg;
    tail_next   = tail_reg;
    head_next   = head_reg;
    last_next   = last_reg;
    credit_next = credit_reg;
    cur_q_next  = cur_q_reg;
    left_next   = left_reg;
    wrr_next    = wrr_reg;
    lvl_next    = lvl_reg;
    fst_next    = fst_reg;
    sv_next     = 1'b0;
    sq_next     = sq_reg;
    ss_next     = ss_reg;
    sf_next     = sf_reg;
    sc_next     = sc_reg;
    rdata_next  = '0;
    lim_c       = burst_lim;
    reload_c    = 1'b0;
    issue_c     = 1'b0;
    // Register port
    if (wr_in) begin
      case (addr_in)
        OFS_CTRL:   ctrl_next = wdata_in[3:0];
        OFS_WEIGHT: weight_next = wdata_in[23:0];
        OFS_QCLASS: qclass_next = wdata_in[15:0];
        default: begin
          if (addr_in[7:5] == DB_PAGE) tail_next[addr_in[4:2]] = wdata_in[PW-1:0];
        end
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        OFS_CTRL:   rdata_next = {28'h0, ctrl_reg};
        OFS_WEIGHT: rdata_next = {8'h00, weight_reg};
        OFS_QCLASS: rdata_next = {16'h0000, qclass_reg};
        OFS_STATUS: rdata_next = {credit_reg[2], credit_reg[1], credit_reg[0],
                                  state_reg, cur_q_reg};
        OFS_CAP:    rdata_next = {30'h0, cap_reg};
        default: begin
          if (addr_in[7:5] == DB_PAGE) rdata_next = {28'h0, tail_reg[addr_in[4:2]]};
        end
      endcase
    end
    // Arbitration; hold_in keeps new starts back while a completion publishes state
    case (state_reg)
      AS_ARB: begin
        if (!hold_in) begin
          if (!ctrl_reg[CTRL_WRR_BIT]) begin
            p = rr_pick(pend, last_reg[4]);
            if (p[QW]) last_next[4] = p[QW-1:0];
            wrr_next = 1'b0;
          end else if (pend[0]) begin
            p = {1'b1, QW'(0)};
            wrr_next = 1'b0;
          end else begin
            p = rr_pick(cls_mask[CLS_URGENT], last_reg[0]);
            wrr_next = 1'b0;
            if (p[QW]) last_next[0] = p[QW-1:0];
            // Weighted levels in strict order of credit use: high, medium, low
            for (int l = 2; l >= 0; l--) begin
              if (!p[QW] && credit_reg[l] != '0 && rr_pick(cls_mask[l+1], last_reg[l+1]) != '0)
                fl = 2'(l);
            end
            if (!p[QW]) begin
              p = rr_pick(cls_mask[fl+2'd1], last_reg[fl+2'd1]);
              if (p[QW] && credit_reg[fl] != '0) begin
                last_next[fl+2'd1] = p[QW-1:0];
                wrr_next = 1'b1;
                lvl_next = fl;
                lim_c = (credit_reg[fl] < burst_lim) ? credit_reg[fl] : burst_lim;
              end else begin
                p = '0;
                // Nothing weighted can proceed: refill all levels
                if ((cls_mask[CLS_HIGH] | cls_mask[CLS_MED] | cls_mask[CLS_LOW]) != '0) begin
                  reload_c = 1'b1;
                  credit_next[0] = CW'(weight_reg[WT_HIGH_LSB+:8]) + CW'(1);
                  credit_next[1] = CW'(weight_reg[WT_MED_LSB+:8]) + CW'(1);
                  credit_next[2] = CW'(weight_reg[WT_LOW_LSB+:8]) + CW'(1);
                end
              end
            end
          end
          if (p[QW]) begin
            cur_q_next = p[QW-1:0];
            left_next  = lim_c;
            state_next = AS_RUN;
          end
        end
      end
      AS_RUN: begin
        if (left_reg == '0 || !pend[cur_q_reg]) begin
          state_next = AS_ARB;
        end else if (!hold_in) begin
          issue_c = 1'b1;
          sv_next = 1'b1;
          sq_next = cur_q_reg;
          ss_next = head_reg[cur_q_reg];
          head_next[cur_q_reg] = head_reg[cur_q_reg] + PW'(1);
          left_next = left_reg - CW'(1);
          if (wrr_reg && credit_reg[lvl_reg] != '0)
            credit_next[lvl_reg] = credit_reg[lvl_reg] - CW'(1);
          sf_next = FU_NONE;
          sc_next = SC_OK;
          if (fused_first_in[cur_q_reg]) begin
            sf_next = FU_FIRST;
            sc_next = lba_mismatch_in[cur_q_reg] ? SC_INVALID_FIELD : SC_OK;
            fst_next = lba_mismatch_in[cur_q_reg] ? SC_INVALID_FIELD : SC_OK;
            state_next = AS_FUSE;
          end
        end
      end
      AS_FUSE: begin
        if (first_fail_in) fst_next = SC_ABORT_FUSED;
        // Second half is issued even past the burst count; the pair is never split
        if (!hold_in) begin
          issue_c = 1'b1;
          sv_next = 1'b1;
          sq_next = cur_q_reg;
          ss_next = head_reg[cur_q_reg];
          sf_next = FU_SECOND;
          sc_next = first_fail_in ? SC_ABORT_FUSED : fst_reg;
          head_next[cur_q_reg] = head_reg[cur_q_reg] + PW'(1);
          left_next = (left_reg == '0) ? '0 : left_reg - CW'(1);
          if (wrr_reg && credit_reg[lvl_reg] != '0)
            credit_next[lvl_reg] = credit_reg[lvl_reg] - CW'(1);
          state_next = AS_RUN;
        end
      end
      default: state_next = AS_ARB;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg  <= AS_ARB;
      ctrl_reg   <= CTRL_RST;
      weight_reg <= WEIGHT_RST;
      qclass_reg <= QCLASS_RST;
      for (int i = 0; i < NUM_Q; i++) begin
        tail_reg[i] <= '0;
        head_reg[i] <= '0;
      end
      for (int i = 0; i < 5; i++) last_reg[i] <= '0;
      for (int i = 0; i < 3; i++) credit_reg[i] <= CREDIT_RST;
      cur_q_reg <= '0;
      left_reg  <= '0;
      wrr_reg   <= 1'b0;
      lvl_reg   <= '0;
      fst_reg   <= SC_OK;
      rdata_reg <= '0;
      sv_reg    <= 1'b0;
      sq_reg    <= '0;
      ss_reg    <= '0;
      sf_reg    <= FU_NONE;
      sc_reg    <= SC_OK;
      cap_reg   <= CAP_VALUE;
    end else begin
      state_reg  <= state_next;
      ctrl_reg   <= ctrl_next;
      weight_reg <= weight_next;
      qclass_reg <= qclass_next;
      tail_reg   <= tail_next;
      head_reg   <= head_next;
      last_reg   <= last_next;
      credit_reg <= credit_next;
      cur_q_reg  <= cur_q_next;
      left_reg   <= left_next;
      wrr_reg    <= wrr_next;
      lvl_reg    <= lvl_next;
      fst_reg    <= fst_next;
      rdata_reg  <= rdata_next;
      sv_reg     <= sv_next;
      sq_reg     <= sq_next;
      ss_reg     <= ss_next;
      sf_reg     <= sf_next;
      sc_reg     <= sc_next;
      cap_reg    <= CAP_VALUE;
    end
  end

  assign rdata_out        = rdata_reg;
  assign start_valid_out  = sv_reg;
  assign start_qid_out    = sq_reg;
  assign start_slot_out   = ss_reg;
  assign start_fused_out  = sf_reg;
  assign start_status_out = sc_reg;
  assign capability_arbitration_support_out = cap_reg;

  // ****************************************
  // Checks
  // ****************************************
  logic [CW:0] run_cnt_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) run_cnt_reg <= '0;
    else if (state_reg == AS_ARB) run_cnt_reg <= '0;
    else if (issue_c) run_cnt_reg <= run_cnt_reg + (CW+1)'(1);
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_first_out;
    start_valid_out && start_fused_out == FU_FIRST;
  endsequence
  sequence s_second_same_q;
    start_valid_out && start_fused_out == FU_SECOND && start_qid_out == $past(start_qid_out);
  endsequence

  a_fuse_atomic: assert property (s_first_out |=> (!start_valid_out) or s_second_same_q)
    else $error("fused pair split by another start");
  a_fuse_invalid: assert property ((s_first_out and start_status_out == SC_INVALID_FIELD)
      |=> !start_valid_out || start_status_out == SC_INVALID_FIELD)
    else $error("fused range mismatch not applied to second half");
  a_fuse_abort: assert property ((state_reg == AS_FUSE && first_fail_in && !hold_in)
      |=> start_valid_out && start_status_out == SC_ABORT_FUSED)
    else $error("second half not aborted after first failed");
  a_admin_first: assert property ((state_reg == AS_ARB && ctrl_reg[CTRL_WRR_BIT] && pend[0]
      && !hold_in) |=> state_reg == AS_RUN && cur_q_reg == '0)
    else $error("admin queue not picked first");
  a_urgent_first: assert property ((state_reg == AS_ARB && ctrl_reg[CTRL_WRR_BIT] && !pend[0]
      && cls_mask[CLS_URGENT] != '0 && !hold_in)
      |=> qclass_reg[2*cur_q_reg+:2] == CLS_URGENT && !wrr_reg)
    else $error("urgent queue not served before weighted");
  a_burst_count: assert property ((state_reg != AS_ARB && $stable(ctrl_reg))
      |-> run_cnt_reg <= (CW+1)'(burst_lim) + (CW+1)'(1))
    else $error("burst count exceeded");
  a_wrr_limit: assert property ((state_reg == AS_ARB && state_next == AS_RUN && wrr_next)
      |=> left_reg <= $past(credit_reg[lvl_next]) && left_reg <= $past(burst_lim))
    else $error("weighted burst above credits or burst");
  a_credit_reload: assert property (reload_c
      |=> credit_reg[0] == CW'($past(weight_reg[WT_HIGH_LSB+:8])) + CW'(1))
    else $error("credits not reloaded from weights");
  a_head_step: assert property (issue_c |-> pend[cur_q_reg] ##1
      start_valid_out && start_slot_out == $past(head_reg[cur_q_reg]))
    else $error("start issued for unsubmitted slot");
  a_cap_value: assert property (capability_arbitration_support_out == CAP_VALUE)
    else $error("capability field wrong");
endmodule // sq_arbiter

// >>> verification/host_model.sv
// Purpose: Host side of the arbiter: tracks queue heads, shows fused head flags
// Assumes: Bench marks the slot of each fused first half in fmask_in
// Notes:   Head follows the start reports, so the flag drops once consumed
`timescale 1ns/1ns
module host_model import arb_pkg::*; (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Start reports
  input  wire logic             sv_in,
  input  wire logic [QW-1:0]    qid_in,
  input  wire logic [PW-1:0]    slot_in,
  // Fused slot map and head flags
  input  wire logic [15:0]      fmask_in [NUM_Q],
  output logic      [NUM_Q-1:0] fused_first_out
);
  logic [PW-1:0] head_reg [NUM_Q];
  // Pointers wrap at 16, so a pair at the last slot continues at slot 0
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int q = 0; q < NUM_Q; q++) head_reg[q] <= '0;
    end else if (sv_in) begin
      head_reg[qid_in] <= slot_in + 4'h1;
    end
  end
  // A start report already names the consumed slot, so the flag follows the next slot at once
  always_comb begin
    for (int q = 0; q < NUM_Q; q++) begin
      if (sv_in && qid_in == QW'(q)) fused_first_out[q] = fmask_in[q][slot_in + 4'h1];
      else fused_first_out[q] = fmask_in[q][head_reg[q]];
    end
  end
endmodule // host_model

// >>> verification/submission_queue_command_arbiter_bench.sv
// Purpose: Self-checking bench for the submission queue arbiter
// Assumes: Starts are logged in the cycle they stand
// Notes:   Doorbells are rung under hold so every queue competes at once
`timescale 1ns/1ns
module submission_queue_command_arbiter_bench;
  import arb_pkg::*;
  logic             clk_in, rst_in, wr_in, rd_in, hold_in, first_fail_in;
  logic [7:0]       addr_in;
  logic [31:0]      wdata_in, rdata_out, v;
  logic [NUM_Q-1:0] fused_first_in, lba_mismatch_in;
  logic             start_valid_out;
  logic [QW-1:0]    start_qid_out;
  logic [PW-1:0]    start_slot_out;
  logic [1:0]       start_fused_out, start_status_out, capability_arbitration_support_out;
  logic [15:0]      fmask [NUM_Q];
  logic [PW-1:0]    tl [NUM_Q];
  logic [QW-1:0]    sq [$];
  logic [PW-1:0]    ss [$];
  logic [1:0]       sf [$];
  logic [1:0]       st [$];
  int               sc [$];
  int               errors, compares, cyc;

  sq_arbiter i_sq_arbiter (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .fused_first_in(fused_first_in), .lba_mismatch_in(lba_mismatch_in),
    .first_fail_in(first_fail_in), .hold_in(hold_in), .start_valid_out(start_valid_out),
    .start_qid_out(start_qid_out), .start_slot_out(start_slot_out),
    .start_fused_out(start_fused_out), .start_status_out(start_status_out),
    .capability_arbitration_support_out(capability_arbitration_support_out));
  host_model i_host_model (.clk_in(clk_in), .rst_in(rst_in), .sv_in(start_valid_out),
    .qid_in(start_qid_out), .slot_in(start_slot_out), .fmask_in(fmask),
    .fused_first_out(fused_first_in));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // ****
  // Start log
  // ****
  // Logged mid-cycle, where the registered start outputs have settled
  always @(negedge clk_in) begin
    cyc++;
    if (start_valid_out === 1'b1) begin
      sq.push_back(start_qid_out);
      ss.push_back(start_slot_out);
      sf.push_back(start_fused_out);
      st.push_back(start_status_out);
      sc.push_back(cyc);
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic wrap_up;
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic ring(input int q, input int n);
    tl[q] = tl[q] + PW'(n);
    wr(8'h20 + 8'(4 * q), 32'(tl[q]));
  endtask
  task automatic hold(input logic h);
    @(posedge clk_in);
    hold_in <= h;
  endtask
  task automatic grab(input int n);
    sq.delete();
    ss.delete();
    sf.delete();
    st.delete();
    sc.delete();
    hold(1'b0);
    for (int k = 0; k < 400 && sq.size() < n; k++) @(posedge clk_in);
    if (sq.size() < n) begin
      errors++;
      wrap_up();
    end
    // Idle time shows that no start appears without a doorbell
    repeat (8) @(posedge clk_in);
    chk(sq.size(), n);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    chk(capability_arbitration_support_out, CAP_VALUE);
    rd(OFS_CAP);
    chk(v, 32'(CAP_VALUE));
    rd(OFS_CTRL);
    chk(v, 32'(CTRL_RST));
    rd(OFS_WEIGHT);
    chk(v, 32'(WEIGHT_RST));
    rd(OFS_QCLASS);
    chk(v, 32'(QCLASS_RST));
    rd(OFS_STATUS);
    chk(v, {CREDIT_RST, CREDIT_RST, CREDIT_RST, 5'h00});
    rd(8'h14);
    chk(v, 32'h0);
  endtask
  task automatic t_rr;
    logic [7:0] m;
    m = 8'h00;
    hold(1'b1);
    for (int q = 0; q < 4; q++) ring(q, 2);
    chk(sq.size(), 0);
    grab(8);
    for (int i = 0; i < 8; i++) begin
      chk(ss[i], i / 4);
      chk(sf[i], FU_NONE);
      if (i > 0) chk(sq[i] !== sq[i-1], 1);
      if (i < 4) m = m | (8'h01 << sq[i]);
    end
    chk(m, 8'h0F);
  endtask
  task automatic t_burst;
    wr(OFS_CTRL, 32'h2);
    hold(1'b1);
    ring(1, 4);
    ring(2, 4);
    grab(8);
    for (int k = 0; k < 4; k++) begin
      chk(sq[2*k] === sq[2*k+1], 1);
      if (k < 3) chk(sq[2*k] !== sq[2*k+2], 1);
    end
  endtask
  task automatic t_wrr;
    logic [QW-1:0] e [5];
    e = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3};
    wr(OFS_CTRL, 32'hF);
    // Only one queue is urgent, so the weighted levels still get served
    wr(OFS_QCLASS, 32'hFFD3);
    hold(1'b1);
    ring(3, 1);
    ring(2, 1);
    ring(1, 1);
    ring(0, 2);
    grab(5);
    for (int i = 0; i < 5; i++) chk(sq[i], e[i]);
  endtask
  task automatic t_weight;
    wr(OFS_WEIGHT, 32'h0);
    wr(OFS_QCLASS, 32'hFED3);
    hold(1'b1);
    ring(2, 3);
    ring(4, 3);
    grab(6);
    // One credit per level: levels alternate although the burst is unlimited
    for (int i = 0; i < 6; i++) begin
      chk(sq[i] === 3'h2 || sq[i] === 3'h4, 1);
      if (i > 0) chk(sq[i] !== sq[i-1], 1);
    end
  endtask
  task automatic t_fuse(input int q, input logic f, input logic [1:0] e1, input logic [1:0] e2);
    int j;
    j = -1;
    wr(OFS_CTRL, 32'h0);
    fmask[q][tl[q]] = 1'b1;
    first_fail_in <= f;
    lba_mismatch_in <= (f ? 8'h00 : 8'h01 << q);
    hold(1'b1);
    ring(q, 2);
    ring(5, 1);
    grab(3);
    for (int i = 0; i < 2; i++) if (sq[i] === QW'(q) && sf[i] === FU_FIRST && j < 0) j = i;
    chk(j >= 0, 1);
    if (j >= 0) begin
      chk(st[j], e1);
      chk(sq[j+1], q);
      chk(ss[j+1], PW'(ss[j] + 4'h1));
      chk(sf[j+1], FU_SECOND);
      chk(st[j+1], e2);
      chk(sc[j+1] - sc[j], 1);
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    hold_in = 1'b0;
    first_fail_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    lba_mismatch_in = '0;
    for (int q = 0; q < NUM_Q; q++) begin
      fmask[q] = 16'h0000;
      tl[q] = '0;
    end
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_rr();
    t_burst();
    t_wrr();
    t_weight();
    t_fuse(1, 1'b1, SC_OK, SC_ABORT_FUSED);
    t_fuse(3, 1'b0, SC_INVALID_FIELD, SC_INVALID_FIELD);
    wrap_up();
  end
endmodule // submission_queue_command_arbiter_bench
